// >>> hw/cmb_pkg.sv
// constants for the can message buffer block: register indices, fields, resets
// assumes a byte-wide register port and a byte-wide message ram port outside
package cmb_pkg;
    // register indices on the byte port
    localparam logic [3:0] IDX_CTRL  = 4'h0;
    localparam logic [3:0] IDX_TXC   = 4'h1;
    localparam logic [3:0] IDX_RXST  = 4'h2;
    localparam logic [3:0] IDX_REMAP = 4'h3;
    localparam logic [3:0] IDX_ERRST = 4'h4;
    localparam logic [3:0] IDX_TEC   = 4'h5;
    localparam logic [3:0] IDX_REC   = 4'h6;
    localparam logic [3:0] IDX_MESSAGE_COUNT_REG  = 4'h7;
    localparam logic [3:0] IDX_BRP   = 4'h8;
    localparam logic [3:0] IDX_BT0   = 4'h9;
    localparam logic [3:0] IDX_BT1   = 4'hA;
    localparam logic [3:0] IDX_FILTER_MASK_CONTROL = 4'hB;
    localparam logic [3:0] IDX_BITOP = 4'hC;
    // reset values
    localparam logic [7:0] RST_CTRL  = 8'h01;
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [7:0] RST_MESSAGE_COUNT_REG  = 8'hC0;
    localparam logic [7:0] RST_BT0   = 8'h18;
    localparam logic [7:0] RST_BT1   = 8'h0E;
    // field positions
    localparam int CTRL_INIT  = 0;
    localparam int CTRL_SLEEP = 2;
    localparam int CTRL_FRAME_START_ENABLE  = 4;
    localparam int REMAP_EN   = 7;
    localparam int TXC_REQ0   = 0;
    localparam int TXC_REQ1   = 1;
    localparam int TXC_PRIO   = 4;
    localparam int MESSAGE_COUNT_REG_BASE_LO = 0;
    // bit op register: [7] set value, [6] target remap, [2:0] bit number
    localparam int BOP_VAL    = 7;
    localparam int BOP_REMAP  = 6;
    // message ram layout
    localparam logic [8:0] SLOT_TX0   = 9'h000;
    localparam logic [8:0] SLOT_TX1   = 9'h010;
    localparam logic [8:0] SLOT_RX0   = 9'h020;
    localparam logic [8:0] SLOT_MASK0 = 9'h020;
    localparam logic [8:0] SLOT_MASK1 = 9'h040;
    localparam logic [8:0] SLOT_RX15  = 9'h110;
    localparam logic [3:0] OFS_TCON   = 4'h0;
    localparam logic [3:0] OFS_ID0    = 4'h2;
    localparam logic [3:0] OFS_DATA0  = 4'h8;
    localparam int         TCON_IDE   = 7;
    localparam logic [3:0] DLC_MAX    = 4'h8;
    localparam logic [2:0] ID_STD_LAST = 3'd1;
    localparam logic [2:0] ID_EXT_LAST = 3'd4;
    // state of the fetch engine
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_TCON  = 5'b00010,
        ST_ID    = 5'b00100,
        ST_DATA  = 5'b01000,
        ST_SEND  = 5'b10000
    } cmb_state_t;
endpackage : cmb_pkg

// >>> hw/cmb_msgbuf.sv
// register file and transmit fetch engine of the can message buffer block
// assumes a byte-wide ram read port with data one cycle after the strobe,
// and a protocol core that takes bytes from core_byte, while bus_tx_pin is held recessive here
module cmb_msgbuf
    import cmb_pkg::*;
#(
    parameter int RAM_AW = 16
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // message ram read port
    output logic                   ram_rd,
    output logic      [RAM_AW-1:0] ram_addr,
    input  wire logic [7:0]        ram_rdata,
    // protocol core side
    output logic                   core_byte_valid,
    output logic      [7:0]        core_byte,
    output logic                   core_frame_start,
    input  wire logic              core_frame_done,
    input  wire logic [7:0]        core_tec,
    input  wire logic [7:0]        core_rec,
    input  wire logic [7:0]        core_rx_status,
    input  wire logic              bus_rx_pin,
    output logic                   bus_tx_pin,
    // per-buffer interrupt lines
    output logic                   tx0_irq,
    output logic                   tx1_irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] txc;
        logic [7:0] remap;
        logic [7:0] errst;
        logic [7:0] brp;
        logic [7:0] bt0;
        logic [7:0] bt1;
        logic [7:0] filter_mask_control;
        logic [7:0] message_count_reg;
        logic [7:0] rdata;
        cmb_state_t st;
        logic       buf_sel;
        logic       is_ext;
        logic [3:0] nbytes;
        logic [2:0] idx;
        logic       pend;
        logic       byte_v;
        logic [7:0] byte_q;
        logic       fstart;
        logic [1:0] irq;
    } cmb_regs_t;

    cmb_regs_t r_q;
    cmb_regs_t r_d;
    logic [8:0] slot_base;
    logic [3:0] dlc;

    // transmit buffer slot and clipped length code
    assign slot_base = r_q.buf_sel ? SLOT_TX1 : SLOT_TX0;
    assign dlc       = (ram_rdata[3:0] > DLC_MAX) ? DLC_MAX : ram_rdata[3:0];

    // next state: register writes, bit ops, fetch engine
    always_comb begin
        r_d = r_q;
        r_d.byte_v = 1'b0;
        r_d.fstart = 1'b0;
        r_d.irq    = 2'b00;
        r_d.rdata  = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                IDX_CTRL:  r_d.rdata = r_q.ctrl;
                IDX_TXC:   r_d.rdata = r_q.txc;
                IDX_RXST:  r_d.rdata = core_rx_status;
                IDX_REMAP: r_d.rdata = r_q.remap;
                IDX_ERRST: r_d.rdata = r_q.errst;
                IDX_TEC:   r_d.rdata = core_tec;
                IDX_REC:   r_d.rdata = core_rec;
                IDX_MESSAGE_COUNT_REG:  r_d.rdata = r_q.message_count_reg;
                IDX_BRP:   r_d.rdata = r_q.brp;
                IDX_BT0:   r_d.rdata = r_q.bt0;
                IDX_BT1:   r_d.rdata = r_q.bt1;
                IDX_FILTER_MASK_CONTROL: r_d.rdata = r_q.filter_mask_control;
                default:   r_d.rdata = 8'h00;
            endcase
        end
        if (reg_wr) begin
            unique case (reg_addr)
                IDX_CTRL:  r_d.ctrl  = reg_wdata;
                IDX_TXC:   r_d.txc   = reg_wdata | (r_q.txc & 8'h03);
                IDX_REMAP: r_d.remap = reg_wdata;
                IDX_ERRST: r_d.errst = reg_wdata;
                IDX_BRP:   r_d.brp   = reg_wdata;
                IDX_BT0:   r_d.bt0   = reg_wdata;
                IDX_BT1:   r_d.bt1   = reg_wdata;
                IDX_FILTER_MASK_CONTROL: r_d.filter_mask_control = reg_wdata;
                IDX_BITOP: begin
                    // single-bit access limited to four bits
                    if (reg_wdata[BOP_REMAP]) begin
                        if (reg_wdata[2:0] == 3'd7)
                            r_d.remap[REMAP_EN] = reg_wdata[BOP_VAL];
                    end else if (reg_wdata[2:0] == 3'(CTRL_FRAME_START_ENABLE) || reg_wdata[2:0] == 3'(CTRL_SLEEP)
                                 || reg_wdata[2:0] == 3'(CTRL_INIT)) begin
                        r_d.ctrl[reg_wdata[2:0]] = reg_wdata[BOP_VAL];
                    end
                end
                default: ;
            endcase
        end
        // fetch engine reads control, id, data from ram
        unique case (r_q.st)
            ST_IDLE: begin
                if (!r_q.ctrl[CTRL_INIT] && (r_q.txc[TXC_REQ0] || r_q.txc[TXC_REQ1])) begin
                    if (r_q.txc[TXC_REQ0] && r_q.txc[TXC_REQ1])
                        r_d.buf_sel = r_q.txc[TXC_PRIO];
                    else
                        r_d.buf_sel = r_q.txc[TXC_REQ1];
                    r_d.pend = 1'b1;
                    r_d.st   = ST_TCON;
                end
            end
            ST_TCON: begin
                if (r_q.pend) begin
                    r_d.pend = 1'b0; // read issued
                end else begin
                    r_d.is_ext = ram_rdata[TCON_IDE];
                    r_d.nbytes = dlc;
                    r_d.byte_q = {ram_rdata[7:4], dlc};
                    r_d.byte_v = 1'b1;
                    r_d.fstart = 1'b1;
                    r_d.idx    = 3'd0;
                    r_d.pend   = 1'b1;
                    r_d.st     = ST_ID;
                end
            end
            ST_ID: begin
                if (r_q.pend) begin
                    r_d.pend = 1'b0;
                end else begin
                    r_d.byte_q = ram_rdata;
                    r_d.byte_v = 1'b1;
                    r_d.pend   = 1'b1;
                    if (r_q.idx == (r_q.is_ext ? ID_EXT_LAST : ID_STD_LAST)) begin
                        r_d.idx = 3'd0;
                        r_d.st  = (r_q.nbytes == 4'd0) ? ST_SEND : ST_DATA;
                        r_d.pend = (r_q.nbytes != 4'd0);
                    end else begin
                        r_d.idx = r_q.idx + 3'd1;
                    end
                end
            end
            ST_DATA: begin
                if (r_q.pend) begin
                    r_d.pend = 1'b0;
                end else begin
                    r_d.byte_q = ram_rdata;
                    r_d.byte_v = 1'b1;
                    r_d.pend   = 1'b1;
                    r_d.idx    = r_q.idx + 3'd1;
                    if ({1'b0, r_q.idx} == r_q.nbytes - 4'd1) begin
                        r_d.pend = 1'b0;
                        r_d.st   = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (core_frame_done) begin
                    // request served, a new set in the same cycle wins
                    r_d.txc[r_q.buf_sel] = reg_wr && (reg_addr == IDX_TXC) && reg_wdata[r_q.buf_sel];
                    r_d.irq[r_q.buf_sel] = 1'b1;
                    r_d.st = ST_IDLE;
                end
            end
        endcase
        if (r_q.ctrl[CTRL_INIT] && r_q.st != ST_SEND)
            r_d.st = ST_IDLE;
    end

    // ram read address: base plus slot plus byte offset, read only
    always_comb begin
        logic [8:0] ofs;
        ofs = 9'h000;
        unique case (r_q.st)
            ST_TCON: ofs = slot_base + {5'h00, OFS_TCON};
            ST_ID:   ofs = slot_base + {5'h00, OFS_ID0 + {1'b0, r_q.idx}};
            ST_DATA: ofs = slot_base + {5'h00, OFS_DATA0 + {1'b0, r_q.idx}};
            default: ofs = slot_base;
        endcase
        ram_rd   = r_q.pend && (r_q.st != ST_IDLE);
        ram_addr = {r_q.message_count_reg[MESSAGE_COUNT_REG_BASE_LO +: 2], {(RAM_AW-11){1'b0}}, ofs};
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r_q        <= '0;
            r_q.ctrl   <= RST_CTRL;
            r_q.txc    <= RST_ZERO;
            r_q.remap  <= RST_ZERO;
            r_q.errst  <= RST_ZERO;
            r_q.brp    <= RST_ZERO;
            r_q.filter_mask_control  <= RST_ZERO;
            r_q.message_count_reg   <= RST_MESSAGE_COUNT_REG;
            r_q.bt0    <= RST_BT0;
            r_q.bt1    <= RST_BT1;
            r_q.st     <= ST_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs
    assign reg_rdata        = r_q.rdata;
    assign core_byte_valid  = r_q.byte_v;
    assign core_byte        = r_q.byte_q;
    assign core_frame_start = r_q.fstart;
    assign bus_tx_pin       = bus_rx_pin | ~r_q.ctrl[CTRL_INIT] | 1'b1; // always recessive, forced high whatever bus_rx_pin and ctrl hold
    assign tx0_irq          = r_q.irq[0];
    assign tx1_irq          = r_q.irq[1];
endmodule : cmb_msgbuf

// >>> sim/cmb_msgbuf_checker.sv
// assertions on the ports of the can message buffer block
// assumes one clock domain and a synchronous active-low reset
module cmb_msgbuf_checker #(
    parameter int RAM_AW = 16
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              ram_rd,
    input wire logic [RAM_AW-1:0] ram_addr,
    input wire logic              core_byte_valid,
    input wire logic              core_frame_start,
    input wire logic              core_frame_done,
    input wire logic              bus_tx_pin,
    input wire logic              tx0_irq,
    input wire logic              tx1_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // steps of a fetch and of a completion
    sequence s_fetched; $past(ram_rd, 2); endsequence
    sequence s_irq_soon; ##[0:4] (tx0_irq || tx1_irq); endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
    a_byte_from_ram: assert property (core_byte_valid |-> s_fetched) else $error("byte not fetched");
    a_start_first: assert property (core_frame_start |-> core_byte_valid) else $error("start without byte");
    a_tx_window: assert property (ram_rd |-> ram_addr[RAM_AW-1:5] == '0) else $error("fetch outside tx");
    a_irq_follows: assert property (core_frame_done |-> s_irq_soon) else $error("no completion irq");
    a_irq0_pulse: assert property (tx0_irq |=> !tx0_irq) else $error("irq0 too long");
    a_irq_split: assert property (!(tx0_irq && tx1_irq)) else $error("both irqs at once");
    a_tx_recessive: assert property (bus_tx_pin) else $error("tx pin not recessive");
endmodule : cmb_msgbuf_checker

bind cmb_msgbuf cmb_msgbuf_checker #(.RAM_AW(RAM_AW)) chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_rd(ram_rd), .ram_addr(ram_addr),
    .core_byte_valid(core_byte_valid), .core_frame_start(core_frame_start),
    .core_frame_done(core_frame_done), .bus_tx_pin(bus_tx_pin), .tx0_irq(tx0_irq), .tx1_irq(tx1_irq));

// >>> sim/cmb_bus_partner.sv
// message ram and protocol core stand-in beside the message buffer block
// assumes ram data one cycle after the strobe and a loop-back transceiver
module cmb_bus_partner #(
    parameter int RAM_AW   = 16,
    parameter int DONE_DLY = 6
) (
    input  wire logic              sys_clk,
    input  wire logic              ram_rd,
    input  wire logic [RAM_AW-1:0] ram_addr,
    output logic      [7:0]        ram_rdata,
    input  wire logic              core_byte_valid,
    input  wire logic [7:0]        core_byte,
    input  wire logic              core_frame_start,
    output logic                   core_frame_done,
    input  wire logic              bus_tx_pin,
    output logic                   bus_rx_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [512];
    int         left;
    int         dly = 0;
    initial ram_rdata = 8'h5A;
    initial core_frame_done = 1'b0;
    // transceiver echoes the transmit line
    assign bus_rx_pin = bus_tx_pin;
    // read port, data toggles when not read
    always @(posedge sys_clk) begin
        ram_rdata <= ram_rd ? mem[ram_addr[8:0]] : ~ram_rdata;
    end
    // count frame bytes, then report the frame sent
    always @(posedge sys_clk) begin
        core_frame_done <= 1'b0;
        if (core_byte_valid) begin
            if (core_frame_start) left = (core_byte[7] ? 5 : 2) + ((core_byte[3:0] > 8) ? 8 : core_byte[3:0]);
            else left = left - 1;
            if (left == 0) dly = DONE_DLY;
        end else if (dly > 0) begin
            dly = dly - 1;
            if (dly == 0) core_frame_done <= 1'b1;
        end
    end
endmodule : cmb_bus_partner

// >>> sim/cmb_msgbuf_tb_top.sv
// self-checking bench for the can message buffer block
// assumes the partner model holds the message ram and answers frames
module cmb_msgbuf_tb_top;
    import cmb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bus_rx_pin, bus_tx_pin;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, ram_rdata, core_byte, rv;
    logic [7:0] core_tec = 8'h00, core_rec = 8'h00, core_rx_status = 8'h00;
    logic ram_rd, core_byte_valid, core_frame_start, core_frame_done, tx0_irq, tx1_irq;
    logic [15:0] ram_addr;
    logic [7:0] rst_tab [12] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h18, 8'h0E, 8'h00};
    logic [7:0] got_q[$], exp_q[$], irq_q[$], v;
    int err_total = 0, checks_done = 0, cyc = 0, k;
    cmb_msgbuf cmb_msgbuf_i (.*);
    cmb_bus_partner ram_i (.sys_clk, .ram_rd, .ram_addr, .ram_rdata, .core_byte_valid, .core_byte,
        .core_frame_start, .core_frame_done, .bus_tx_pin, .bus_rx_pin);
    initial forever #12.5 sys_clk = ~sys_clk;
    // capture frames and completions, bound the run
    always @(posedge sys_clk) begin
        if (core_byte_valid) got_q.push_back(core_byte);
        if (tx0_irq) irq_q.push_back(8'h00);
        if (tx1_irq) irq_q.push_back(8'h01);
        cyc++;
        if (cyc == 20000) begin err_total++; wrap_up(); end
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk); reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk); reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk); reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    // expected fetch of one buffer: clipped tcon, id bytes, data bytes
    task automatic add_frame(input int b);
        logic [7:0] t;
        int n;
        t = ram_i.mem[b*16];
        n = (t[3:0] > 8) ? 8 : t[3:0];
        exp_q.push_back({t[7:4], 4'(n)});
        for (int j = 2; j <= (t[7] ? 6 : 3); j++) exp_q.push_back(ram_i.mem[b*16+j]);
        for (int j = 0; j < n; j++) exp_q.push_back(ram_i.mem[b*16+8+j]);
    endtask : add_frame
    task automatic run_check(input int nirq);
        int c;
        c = 0;
        while (irq_q.size() < nirq && c < 3000) begin @(posedge sys_clk); c++; end
        repeat (4) @(posedge sys_clk);
        cmp(8'(got_q.size()), 8'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0) cmp(got_q.pop_front(), exp_q.pop_front());
        got_q.delete(); exp_q.delete();
    endtask : run_check
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial begin
        void'($urandom(88));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin rd(4'(i)); cmp(rv, rst_tab[i]); end
        rd(4'hD); cmp(rv, 8'h00);
        foreach (rst_tab[i]) if (i inside {3, 4, 8, 9, 10, 11}) begin
            v = $urandom; wr(4'(i), v); rd(4'(i)); cmp(rv, v);
        end
        core_tec <= $urandom; core_rec <= $urandom; core_rx_status <= $urandom;
        wr(IDX_MESSAGE_COUNT_REG, 8'h3F); rd(IDX_MESSAGE_COUNT_REG); cmp(rv, 8'hC0);
        wr(IDX_TEC, 8'hFF); rd(IDX_TEC); cmp(rv, core_tec);
        rd(IDX_REC); cmp(rv, core_rec);
        wr(IDX_RXST, 8'hFF); rd(IDX_RXST); cmp(rv, core_rx_status);
        wr(IDX_CTRL, 8'h01); wr(IDX_BITOP, 8'h84); rd(IDX_CTRL); cmp(rv, 8'h11);
        wr(IDX_BITOP, 8'h83); rd(IDX_CTRL); cmp(rv, 8'h11);
        wr(IDX_REMAP, 8'h00); wr(IDX_BITOP, 8'hC7); rd(IDX_REMAP); cmp(rv, 8'h80);
        wr(IDX_BITOP, 8'h04);
        for (int j = 0; j < 32; j++) ram_i.mem[j] = $urandom;
        ram_i.mem[0] = 8'h03;
        ram_i.mem[16] = 8'h8C;
        wr(IDX_TXC, 8'h10);
        wr(IDX_CTRL, 8'h00);
        repeat (40) @(posedge sys_clk);
        cmp(8'(got_q.size()), 8'h00);
        wr(IDX_TXC, 8'h13);
        add_frame(1); add_frame(0);
        run_check(2);
        cmp(irq_q.pop_front(), 8'h01);
        cmp(irq_q.pop_front(), 8'h00);
        rd(IDX_TXC); cmp(rv, 8'h10);
        for (int i = 0; i < 6; i++) begin
            k = $urandom % 2;
            ram_i.mem[k*16] = $urandom & 8'h8F;
            wr(IDX_TXC, {3'h0, 1'($urandom), 2'h0, 2'(k + 1)});
            add_frame(k);
            run_check(1);
            cmp(irq_q.pop_front(), 8'(k));
        end
        wrap_up();
    end
endmodule : cmb_msgbuf_tb_top
